// ### logic/sic_defs.svh
// constants of the slot id and secondary clock control register bank
`ifndef SIC_DEFS_SVH
`define SIC_DEFS_SVH

`define SIC_ADDR_W 8
`define SIC_DATA_W 32

// register byte offsets
`define SIC_OFF_SLOT_ID 8'ha0
`define SIC_OFF_CLK_CTRL 8'ha4

// slot identification dword
`define SIC_CAP_CODE 8'h04
`define SIC_NEXT_LINK 8'hb0
`define SIC_SLOT_NUM_LSB 16
`define SIC_SLOT_NUM_MSB 20
`define SIC_FIRST_BIT 21
`define SIC_CHASSIS_LSB 24
`define SIC_CHASSIS_MSB 31
`define SIC_SLOT_NUM_RST 5'h00
`define SIC_CHASSIS_RST 8'h00

// link value for the preceding capability once slot id joins the chain
`define SIC_CHAIN_LINK 8'ha0

// clock control dword
`define SIC_NUM_CLKS 4
`define SIC_GATE_CODE_RST 2'h0
`define SIC_GATE_OFF 2'h3
`define SIC_STOP_BIT 13
`define SIC_CLKRUN_EN_BIT 14
`define SIC_CLKRUN_MODE_BIT 15
`define SIC_MODE_RST 1'h0

// power state code meaning D3
`define SIC_PWR_D3 2'h3

`endif

// ### logic/sic_pkg.sv
// types of the slot id and secondary clock control register bank
`include "sic_defs.svh"
package sic_pkg;

  typedef struct packed {
    logic [`SIC_ADDR_W-1:0] addr;
    logic [`SIC_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } sic_bus_req_s;

  typedef struct packed {
    logic [4:0] slot_number;
    logic first_in_chassis;
    logic [7:0] chassis_number;
  } sic_slot_info_s;

  typedef enum logic [1:0] {
    SIC_STRAP_FILL1,
    SIC_STRAP_FILL2,
    SIC_STRAP_SAMPLE,
    SIC_STRAP_DONE
  } sic_strap_e;

endpackage

// ### logic/sic_clk_gate.sv
// one gated secondary clock output
`timescale 1ns/10ps
`default_nettype none
`include "sic_defs.svh"
module sic_clk_gate
  import sic_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // control
  input wire logic [1:0] gate_code_in,
  input wire logic stop_in,
  // gated clock
  output logic clk_out,
  output logic running_out
);

  logic run;

  assign run = (gate_code_in != `SIC_GATE_OFF) && !stop_in;
  assign running_out = run;

  // half-rate toggle; held low while gated off
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clk_out <= 1'b0;
    end else if (run) begin
      clk_out <= ~clk_out;
    end else begin
      clk_out <= 1'b0;
    end
  end

endmodule // sic_clk_gate
`default_nettype wire

// ### logic/sic_regs.sv
// slot id capability and secondary clock control register bank
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sic_defs.svh"
module sic_regs
  import sic_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // register port
  input wire sic_bus_req_s bus_in,
  output logic [`SIC_DATA_W-1:0] rdata_out,
  // strap pins, request inputs 3 and 2, active low
  input wire logic [1:0] req_strap_n_in,
  // capability enable from serial memory load
  input wire logic slot_cap_enable_in,
  // bridge state
  input wire logic [1:0] power_state_in,
  input wire logic sec_bus_idle_in,
  input wire logic pri_req_pending_in,
  // secondary clocks
  output logic sec_clock_out_zero,
  output logic sec_clock_out_one,
  output logic sec_clock_out_two,
  output logic sec_clock_out_three,
  // status and configuration
  output logic sec_clk_stopped_out,
  output logic clk_pm_enabled_out,
  output logic [7:0] prev_cap_link_out,
  output sic_slot_info_s slot_info_out
);

  // strap synchroniser
  logic [1:0] strap_meta_reg;
  logic [1:0] strap_sync_reg;
  sic_strap_e strap_state_reg;
  logic cpm_enabled_reg;

  // slot id fields
  logic [4:0] slot_number_reg;
  logic first_in_chassis_reg;
  logic [7:0] chassis_number_reg;

  // clock control fields
  logic [1:0] gate_code_reg [`SIC_NUM_CLKS];
  logic clkrun_en_reg;
  logic clkrun_mode_reg;
  logic stopped_reg;
  logic stop_next;

  logic [`SIC_DATA_W-1:0] rdata_reg;
  logic [`SIC_DATA_W-1:0] read_mux;
  logic wr_slot;
  logic wr_ctrl;
  logic [`SIC_NUM_CLKS-1:0] clk_vec;

  assign wr_slot = bus_in.wr && (bus_in.addr == `SIC_OFF_SLOT_ID);
  assign wr_ctrl = bus_in.wr && (bus_in.addr == `SIC_OFF_CLK_CTRL);

  // strap pins come from outside: two flops before use
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strap_meta_reg <= 2'h3;
      strap_sync_reg <= 2'h3;
    end else begin
      strap_meta_reg <= req_strap_n_in;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // strap caught once the synchroniser holds post-release pin levels
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strap_state_reg <= SIC_STRAP_FILL1;
    end else begin
      unique case (strap_state_reg)
        SIC_STRAP_FILL1: strap_state_reg <= SIC_STRAP_FILL2;
        SIC_STRAP_FILL2: strap_state_reg <= SIC_STRAP_SAMPLE;
        SIC_STRAP_SAMPLE: strap_state_reg <= SIC_STRAP_DONE;
        SIC_STRAP_DONE: strap_state_reg <= SIC_STRAP_DONE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cpm_enabled_reg <= 1'b0;
    end else if (strap_state_reg == SIC_STRAP_SAMPLE) begin
      cpm_enabled_reg <= (strap_sync_reg == 2'h0);
    end
  end

  // slot identification writable fields
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      slot_number_reg <= `SIC_SLOT_NUM_RST;
      first_in_chassis_reg <= 1'b0;
      chassis_number_reg <= `SIC_CHASSIS_RST;
    end else if (wr_slot) begin
      slot_number_reg <= bus_in.wdata[`SIC_SLOT_NUM_MSB:`SIC_SLOT_NUM_LSB];
      first_in_chassis_reg <= bus_in.wdata[`SIC_FIRST_BIT];
      chassis_number_reg <= bus_in.wdata[`SIC_CHASSIS_MSB:`SIC_CHASSIS_LSB];
    end
  end

  // per-output gate codes
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < `SIC_NUM_CLKS; i++) begin
        gate_code_reg[i] <= `SIC_GATE_CODE_RST;
      end
    end else if (wr_ctrl) begin
      for (int i = 0; i < `SIC_NUM_CLKS; i++) begin
        gate_code_reg[i] <= bus_in.wdata[2*i +: 2];
      end
    end
  end

  // clock-run protocol enable: default 1 once the feature is strapped on
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clkrun_en_reg <= 1'b0;
    end else if (strap_state_reg == SIC_STRAP_SAMPLE) begin
      clkrun_en_reg <= (strap_sync_reg == 2'h0);
    end else if (!cpm_enabled_reg) begin
      clkrun_en_reg <= 1'b0;
    end else if (wr_ctrl) begin
      clkrun_en_reg <= bus_in.wdata[`SIC_CLKRUN_EN_BIT];
    end
  end

  // clock-run mode
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clkrun_mode_reg <= `SIC_MODE_RST;
    end else if (wr_ctrl && cpm_enabled_reg) begin
      clkrun_mode_reg <= bus_in.wdata[`SIC_CLKRUN_MODE_BIT];
    end
  end

  // stop decision
  always_comb begin
    stop_next = 1'b0;
    if (cpm_enabled_reg && clkrun_en_reg) begin
      if (!clkrun_mode_reg) begin
        stop_next = (power_state_in == `SIC_PWR_D3);
      end else begin
        stop_next = sec_bus_idle_in && !pri_req_pending_in;
      end
    end
  end

  // the gates read this same flop, so the clock outputs follow the status one cycle later
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stopped_reg <= 1'b0;
    end else begin
      stopped_reg <= stop_next;
    end
  end

  // clock zero feeds internal secondary logic; software keeps it on
  for (genvar g = 0; g < `SIC_NUM_CLKS; g++) begin : g_gate
    sic_clk_gate u_gate (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .gate_code_in(gate_code_reg[g]),
      .stop_in(stopped_reg),
      .clk_out(clk_vec[g]),
      .running_out()
    );
  end

  assign sec_clock_out_zero = clk_vec[0];
  assign sec_clock_out_one = clk_vec[1];
  assign sec_clock_out_two = clk_vec[2];
  assign sec_clock_out_three = clk_vec[3];

  // read decode; unmapped offsets read zero
  always_comb begin
    read_mux = '0;
    unique case (bus_in.addr)
      `SIC_OFF_SLOT_ID: begin
        read_mux[7:0] = `SIC_CAP_CODE;
        read_mux[15:8] = `SIC_NEXT_LINK;
        read_mux[`SIC_SLOT_NUM_MSB:`SIC_SLOT_NUM_LSB] = slot_number_reg;
        read_mux[`SIC_FIRST_BIT] = first_in_chassis_reg;
        read_mux[`SIC_CHASSIS_MSB:`SIC_CHASSIS_LSB] = chassis_number_reg;
      end
      `SIC_OFF_CLK_CTRL: begin
        for (int i = 0; i < `SIC_NUM_CLKS; i++) begin
          read_mux[2*i +: 2] = gate_code_reg[i];
        end
        read_mux[`SIC_STOP_BIT] = stopped_reg;
        read_mux[`SIC_CLKRUN_EN_BIT] = clkrun_en_reg && cpm_enabled_reg;
        read_mux[`SIC_CLKRUN_MODE_BIT] = clkrun_mode_reg;
      end
      default: read_mux = '0;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_reg <= '0;
    end else if (bus_in.rd) begin
      rdata_reg <= read_mux;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata_out = rdata_reg;
  assign sec_clk_stopped_out = stopped_reg;
  assign clk_pm_enabled_out = cpm_enabled_reg;
  assign prev_cap_link_out = slot_cap_enable_in ? `SIC_CHAIN_LINK : `SIC_NEXT_LINK;
  assign slot_info_out.slot_number = slot_number_reg;
  assign slot_info_out.first_in_chassis = first_in_chassis_reg;
  assign slot_info_out.chassis_number = chassis_number_reg;

endmodule // sic_regs
`default_nettype wire

// ### sim/sic_regs_properties.sv
// assertions on the ports of the slot id and clock control bank
`timescale 1ns/10ps
`default_nettype none
`include "sic_defs.svh"
module sic_regs_properties
  import sic_pkg::*;
(
  // watched ports
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire sic_bus_req_s bus_in,
  input wire logic [`SIC_DATA_W-1:0] rdata_out,
  input wire logic [1:0] req_strap_n_in,
  input wire logic slot_cap_enable_in,
  input wire logic [1:0] power_state_in,
  input wire logic sec_bus_idle_in,
  input wire logic pri_req_pending_in,
  input wire logic sec_clock_out_zero,
  input wire logic sec_clk_stopped_out,
  input wire logic clk_pm_enabled_out,
  input wire logic [7:0] prev_cap_link_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  a_cap_read: assert property (
    $past(bus_in.rd && bus_in.addr == 8'ha0) |-> rdata_out[15:0] == 16'hb004) else $error("bad id");
  a_link_steer: assert property (
    prev_cap_link_out == (slot_cap_enable_in ? 8'ha0 : 8'hb0)) else $error("bad link");
  a_stop_read: assert property (
    $past(bus_in.rd && bus_in.addr == 8'ha4) |-> rdata_out[13] == $past(sec_clk_stopped_out))
    else $error("bad stop bit");
  a_stopped_low: assert property (
    $past(sec_clk_stopped_out) |-> !sec_clock_out_zero) else $error("clock runs");
  a_stop_needs_pm: assert property (
    !clk_pm_enabled_out |-> !sec_clk_stopped_out) else $error("stop without pm");
  a_stop_cause: assert property (
    $rose(sec_clk_stopped_out) |->
      $past(power_state_in == 2'h3 || (sec_bus_idle_in && !pri_req_pending_in)))
    else $error("stop without cause");
  a_gate_zero: assert property (
    bus_in.wr && bus_in.addr == 8'ha4 && bus_in.wdata[1:0] == 2'h3 |-> ##2 !sec_clock_out_zero)
    else $error("clock not gated");
  a_strap_low: assert property (
    $rose(clk_pm_enabled_out) |-> $past(req_strap_n_in, 3) == 2'h0) else $error("bad strap");
  cover property ($rose(sec_clk_stopped_out));
  cover property ($rose(clk_pm_enabled_out));
  cover property (bus_in.wr && bus_in.addr == 8'ha4 && bus_in.wdata[1:0] == 2'h3);
endmodule // sic_regs_properties
bind sic_regs sic_regs_properties i_sic_regs_properties (
  .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .req_strap_n_in(req_strap_n_in), .slot_cap_enable_in(slot_cap_enable_in),
  .power_state_in(power_state_in), .sec_bus_idle_in(sec_bus_idle_in),
  .pri_req_pending_in(pri_req_pending_in), .sec_clock_out_zero(sec_clock_out_zero),
  .sec_clk_stopped_out(sec_clk_stopped_out), .clk_pm_enabled_out(clk_pm_enabled_out),
  .prev_cap_link_out(prev_cap_link_out)
);
`default_nettype wire

// ### sim/sic_sec_dev.sv
// secondary bus devices counting the gated clock edges
`timescale 1ns/10ps
`default_nettype none
module sic_sec_dev (
  // gated clocks
  input wire logic [3:0] clk_in,
  // bench control
  input wire logic busy_in,
  input wire logic clr_in,
  // bus state and edge counts
  output logic idle_out,
  output logic [7:0] edges_out [4]
);
  assign idle_out = !busy_in;
  for (genvar i = 0; i < 4; i++) begin : g_cnt
    always @(posedge clk_in[i] or posedge clr_in) begin
      if (clr_in) begin
        edges_out[i] <= 8'h0;
      end else begin
        edges_out[i] <= edges_out[i] + 8'h1;
      end
    end
  end
endmodule // sic_sec_dev
`default_nettype wire

// ### sim/sic_regs_test.sv
// self-checking bench of the slot id and clock control bank
`timescale 1ns/10ps
`default_nettype none
`include "sic_defs.svh"
module sic_regs_test
  import sic_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  sic_bus_req_s bus = '0;
  logic [1:0] strap = 2'h0;
  logic [1:0] pwr = 2'h0;
  logic cap_en = 1'b0, pri = 1'b0, busy = 1'b1, clr = 1'b1, rd_d = 1'b0;
  logic [15:0] lf = 16'hb92b;
  wire logic [31:0] rdata;
  wire logic [3:0] clks;
  wire logic stopped, cpm, idle;
  wire logic [7:0] link;
  wire sic_slot_info_s info;
  wire logic [7:0] edges [4];
  logic [31:0] exp_q [$];
  int fails = 0, n_checks = 0;
  initial forever #12.5 ref_clk_in = ~ref_clk_in;
  sic_regs i_sic_regs (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .bus_in(bus), .rdata_out(rdata),
    .req_strap_n_in(strap), .slot_cap_enable_in(cap_en), .power_state_in(pwr),
    .sec_bus_idle_in(idle), .pri_req_pending_in(pri), .sec_clock_out_zero(clks[0]),
    .sec_clock_out_one(clks[1]), .sec_clock_out_two(clks[2]), .sec_clock_out_three(clks[3]),
    .sec_clk_stopped_out(stopped), .clk_pm_enabled_out(cpm), .prev_cap_link_out(link),
    .slot_info_out(info));
  sic_sec_dev i_sic_sec_dev (.clk_in(clks), .busy_in(busy), .clr_in(clr), .idle_out(idle),
    .edges_out(edges));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk_in);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    bus.rd <= 1'b0;
  endtask
  task automatic runs(input logic [3:0] on);
    clr <= 1'b1;
    wt(1);
    clr <= 1'b0;
    wt(8);
    for (int i = 0; i < 4; i++) chk(32'(edges[i] != 8'h0), 32'(on[i]));
  endtask
  task automatic rst(input logic [1:0] s);
    nrst_in <= 1'b0;
    strap <= s;
    wt(16);
    nrst_in <= 1'b1;
    wt(4);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // read results arrive one cycle after the strobe
  always @(posedge ref_clk_in) begin
    if (rd_d) begin
      chk(rdata, exp_q.pop_front());
    end
    rd_d <= bus.rd;
  end
  initial begin
    wt(20000);
    fails++;
    end_of_test;
  end
  initial begin
    logic [31:0] v;
    rst(2'h0);
    chk(cpm, 32'h1);
    rd(8'ha0, 32'h0000b004);
    lf = lfsr(lf);
    v = {lf, lfsr(lf)};
    wr(8'ha0, v);
    rd(8'ha0, (v & 32'hff3f0000) | 32'h0000b004);
    chk(32'(info), 32'({v[20:16], v[21], v[31:24]}));
    rd(8'ha4, 32'h00004000);
    $display("test slot id done");
    for (int c = 0; c < 4; c++) begin
      wr(8'ha4, {24'h40, {4{c[1:0]}}});
      rd(8'ha4, {24'h40, {4{c[1:0]}}});
      runs({4{c != 3}});
    end
    wr(8'ha4, 32'h4000);
    $display("test gating done");
    pwr <= 2'h3;
    wt(4);
    chk(stopped, 32'h1);
    rd(8'ha4, 32'h6000);
    runs(4'h0);
    pwr <= 2'h0;
    wt(4);
    chk(stopped, 32'h0);
    wr(8'ha4, 32'hc000);
    busy <= 1'b0;
    wt(4);
    chk(stopped, 32'h1);
    pri <= 1'b1;
    wt(4);
    chk(stopped, 32'h0);
    pri <= 1'b0;
    wr(8'ha4, 32'h8000);
    wt(4);
    chk(stopped, 32'h0);
    $display("test clkrun done");
    cap_en <= 1'b1;
    wt(1);
    chk(link, 32'ha0);
    wr(8'ha8, 32'hffffffff);
    rd(8'ha8, 32'h0);
    rd(8'ha4, 32'h8000);
    // let the pending read result be compared before reset clears it
    wt(2);
    rst(2'h3);
    chk(32'(info), 32'h0);
    wr(8'ha4, 32'hc000);
    rd(8'ha4, 32'h0);
    rd(8'ha0, 32'h0000b004);
    chk(cpm, 32'h0);
    wt(2);
    $display("test strap done");
    end_of_test;
  end
endmodule // sic_regs_test
`default_nettype wire
